/* hdl/pta_bar.v */
// Purpose: one base address register with its address decoder
// Assumes: 32-bit pci addresses; upper dword of a 64-bit bar not decoded
// Notes: a zero size mask means the bar is unused and never hits
module pta_bar #(
	parameter [31:0] SIZE_MASK = 32'h00000000,
	parameter IS_IO = 0,
	parameter IS_64 = 0,
	parameter PREFETCH = 0
) (
	input wire clock_in,
	input wire reset_in,
	input wire write_in,
	input wire [31:0] wdata_in,
	input wire [31:0] addr_in,
	input wire io_cycle_in,
	input wire mem_cycle_in,
	output wire hit_out,
	output wire [31:0] value_out
);
	reg [31:0] base;
	wire used;
	wire [3:0] type_bits;

	// only the size-aligned bits can be written by software
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			base <= 32'h00000000;
		end else if (write_in) begin
			base <= wdata_in & SIZE_MASK;
		end
	end

	// io bars show bit0 set; memory bars show width and prefetch
	assign type_bits = IS_IO ? 4'h1 : {PREFETCH != 0, IS_64 != 0, 2'h0};
	assign used = (SIZE_MASK != 32'h00000000);
	assign value_out = used ? (base | {28'h0000000, type_bits}) : 32'h00000000;
	assign hit_out = used && (IS_IO ? io_cycle_in : mem_cycle_in) &&
		((addr_in & SIZE_MASK) == base);
endmodule // pta_bar

/* hdl/pta_defines.vh */
// Purpose: shared constants of the pci target abort block
// Assumes: byte addresses on the local register port, 32-bit words
// Notes: register offsets, field positions, reset values, bus codes
`ifndef PTA_DEFINES_VH
`define PTA_DEFINES_VH

// register offsets (byte addresses)
`define PTA_OFF_ID 8'h00
`define PTA_OFF_CLASS 8'h04
`define PTA_OFF_SUBSYS 8'h08
`define PTA_OFF_CIS 8'h0c
`define PTA_OFF_LAT 8'h10
`define PTA_OFF_INFO 8'h14
`define PTA_OFF_CTRL 8'h18
`define PTA_OFF_STATUS 8'h1c
`define PTA_OFF_MASK 8'h20
`define PTA_OFF_DATA 8'h24
`define PTA_OFF_STATE 8'h28
`define PTA_OFF_BAR0 8'h40

// status / mask bit positions
`define PTA_ST_CLAIM 0
`define PTA_ST_WORD 1
`define PTA_ST_ABORT 2
`define PTA_ST_W 3

// control register
`define PTA_CTRL_EN 0
`define PTA_CTRL_RST 1'h1

// identification defaults (vendor code is arbitrary)
`define PTA_VENDOR_DEF 16'h0abc
`define PTA_DEVICE_DEF 16'h0000
`define PTA_SUBVEN_DEF 16'h0000
`define PTA_SUBSYS_DEF 16'h0000
`define PTA_REV_DEF 8'h01
`define PTA_BASECL_DEF 8'h05
`define PTA_SUBCL_DEF 8'h00
`define PTA_PROGIF_DEF 8'h00
`define PTA_CIS_DEF 32'h00000000
`define PTA_MINGNT_DEF 8'h00
`define PTA_MAXLAT_DEF 8'h00
`define PTA_LAT_RST 8'h00

// base address defaults: size masks, bar0 first in the low word
`define PTA_BAR_MASKS {32'h00000000, 32'h00000000, 32'h00000000, \
	32'hfffffff0, 32'hfffffff0, 32'hfffffffc}
`define PTA_BAR_IO 6'h01
`define PTA_BAR_64 6'h00
`define PTA_BAR_PF 6'h00

// bus commands claimed as target writes
`define PTA_CMD_IO_WR 4'h3
`define PTA_CMD_MEM_WR 4'h7

`endif

/* hdl/pta_sync.v */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to clock_in
// Notes: output moves only once stages two and three agree
module pta_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire clock_in,
	input wire reset_in,
	input wire [W-1:0] pin_in,
	output reg [W-1:0] level_out
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;

	// stage1 feeds stage2 only, so metastability never reaches logic
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
			level_out <= RST_VAL;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				level_out <= stage3;
		end
	end
endmodule // pta_sync

/* hdl/pta_target.v */
// Purpose: pci target write path with back-end abort and config header
// Assumes: pci clock and pins sampled by clock_in, pci period >= 8 clocks
// Notes: bus pins are sampled at the pci falling edge, mid-cycle
// Functional notes
// - on an address decode hit the block drives devsel low to claim the cycle.
// - trdy goes low in the pci cycle after the back-end signalled ready.
// - trdy stays low while ready was low one cycle back; the strobe follows last ready.
// - each accepted write word is shown on the local write data with the strobe low.
// - one cycle after an abort request devsel and trdy go high and stop goes low.
// - the master then releases irdy and in that same cycle stop is released.
// - the abort goes ahead whatever level irdy has.
// - pci, local master, local target and local data widths are 32 or 64, default 32.
// - vendor, device, subsystem ids are 16-bit build values and revision defaults to one.
// - class code is base class 0x05, subclass and interface zero by default.
// - the card information pointer is a 32-bit build value, default zero.
// - latency timer may be built read-only; min grant and max latency default zero.
// - each of six bars may be 32 or 64 bits, memory or io, prefetching or not.
// - by default bar0 is a 4-byte io window, bar1 and bar2 16-byte memory windows.
//
// Implementation choices: the plain strobed port and the register offsets.
`include "pta_defines.vh"
module pta_target #(
	parameter PCI_DATA_WIDTH = 32,
	parameter LM_DATA_WIDTH = 32,
	parameter LT_DATA_WIDTH = 32,
	parameter LOCAL_DATA_WIDTH = 32,
	parameter MT_VARIANT = 1,
	parameter [15:0] VENDOR_ID = `PTA_VENDOR_DEF,
	parameter [15:0] DEVICE_ID = `PTA_DEVICE_DEF,
	parameter [15:0] SUBSYS_VENDOR_ID = `PTA_SUBVEN_DEF,
	parameter [15:0] SUBSYS_ID = `PTA_SUBSYS_DEF,
	parameter [7:0] REVISION_ID = `PTA_REV_DEF,
	parameter [7:0] BASE_CLASS = `PTA_BASECL_DEF,
	parameter [7:0] SUB_CLASS = `PTA_SUBCL_DEF,
	parameter [7:0] PROG_IF = `PTA_PROGIF_DEF,
	parameter [31:0] CIS_POINTER = `PTA_CIS_DEF,
	parameter LAT_READ_ONLY = 0,
	parameter [7:0] MIN_GRANT = `PTA_MINGNT_DEF,
	parameter [7:0] MAX_LATENCY = `PTA_MAXLAT_DEF,
	parameter [191:0] BAR_MASKS = `PTA_BAR_MASKS,
	parameter [5:0] BAR_IO = `PTA_BAR_IO,
	parameter [5:0] BAR_64 = `PTA_BAR_64,
	parameter [5:0] BAR_PF = `PTA_BAR_PF
) (
	input wire clock_in,
	input wire reset_in,
	input wire pci_clk_in,
	input wire frame_n_in,
	input wire irdy_n_in,
	input wire [3:0] cbe_n_in,
	input wire [PCI_DATA_WIDTH-1:0] ad_in,
	output wire devsel_n_out,
	output wire devsel_n_oe_n_out,
	output wire trdy_n_out,
	output wire trdy_n_oe_n_out,
	output wire stop_n_out,
	output wire stop_n_oe_n_out,
	output wire interrupt_line_a_n_out,
	output wire interrupt_line_a_n_oe_n_out,
	input wire local_target_ready_n_in,
	input wire local_abort_request_n_in,
	output reg local_target_xfer_strobe_n_out,
	output reg [LT_DATA_WIDTH-1:0] local_target_write_data_out,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	output reg [31:0] reg_rdata_out,
	output reg irq_out
);
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_CLAIM = 4'b0010;
	localparam [3:0] ST_ABORT = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;

	wire pclk;
	wire frame_n;
	wire irdy_n;
	wire [3:0] cbe_n;
	wire [PCI_DATA_WIDTH-1:0] ad;
	wire tick;
	wire io_cycle;
	wire mem_cycle;
	wire [5:0] bar_hit;
	wire [191:0] bar_value;
	wire [31:0] info_word;
	reg pclk_prev;
	reg frame_prev;
	reg [3:0] state;
	reg devsel_n;
	reg trdy_n;
	reg stop_n;
	reg drive;
	reg rdy_d1_n;
	reg target_en;
	reg [7:0] latency;
	reg [`PTA_ST_W-1:0] status;
	reg [`PTA_ST_W-1:0] mask;
	reg [`PTA_ST_W-1:0] set_ev;
	reg [31:0] last_word;

	// pins from the bus cross into clock_in; control lines reset high, clock and ad low
	pta_sync #(.W(1), .RST_VAL(1'b0)) u_sync_clk (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pin_in(pci_clk_in),
		.level_out(pclk)
	);
	pta_sync #(.W(6), .RST_VAL(6'h3f)) u_sync_ctl (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pin_in({frame_n_in, irdy_n_in, cbe_n_in}),
		.level_out({frame_n, irdy_n, cbe_n})
	);
	pta_sync #(.W(PCI_DATA_WIDTH), .RST_VAL({PCI_DATA_WIDTH{1'b0}})) u_sync_ad (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pin_in(ad_in),
		.level_out(ad)
	);

	// act at the falling pci edge: the master's drive is settled there,
	// and our outputs have half a period to settle before it samples
	assign tick = pclk_prev & ~pclk;
	assign io_cycle = (~cbe_n == `PTA_CMD_IO_WR);
	assign mem_cycle = (~cbe_n == `PTA_CMD_MEM_WR);

	// six base address windows, each with its own decode
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_bar
			pta_bar #(
				.SIZE_MASK(BAR_MASKS[gi*32 +: 32]),
				.IS_IO(BAR_IO[gi]),
				.IS_64(BAR_64[gi]),
				.PREFETCH(BAR_PF[gi])
			) u_bar (
				.clock_in(clock_in),
				.reset_in(reset_in),
				.write_in(reg_write_in &&
					({24'h000000, reg_addr_in} == `PTA_OFF_BAR0 + 4 * gi)),
				.wdata_in(reg_wdata_in),
				.addr_in(ad[31:0]),
				.io_cycle_in(io_cycle),
				.mem_cycle_in(mem_cycle),
				.hit_out(bar_hit[gi]),
				.value_out(bar_value[gi*32 +: 32])
			);
		end
	endgenerate

	// build widths as seen by software
	assign info_word = {28'h0000000, MT_VARIANT != 0,
		(MT_VARIANT != 0) ? (LT_DATA_WIDTH == 64) : (LOCAL_DATA_WIDTH == 64),
		(MT_VARIANT != 0) && (LM_DATA_WIDTH == 64),
		PCI_DATA_WIDTH == 64};

	// tri-state pins, interrupt open-drain: enable low while driving
	assign devsel_n_out = devsel_n;
	assign trdy_n_out = trdy_n;
	assign stop_n_out = stop_n;
	assign devsel_n_oe_n_out = ~drive;
	assign trdy_n_oe_n_out = ~drive;
	assign stop_n_oe_n_out = ~drive;
	assign interrupt_line_a_n_out = 1'b0;
	assign interrupt_line_a_n_oe_n_out = ~irq_out;

	// target state machine, stepped once per pci cycle
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			pclk_prev <= 1'b0;
			frame_prev <= 1'b1;
			state <= ST_IDLE;
			devsel_n <= 1'b1;
			trdy_n <= 1'b1;
			stop_n <= 1'b1;
			drive <= 1'b0;
			rdy_d1_n <= 1'b1;
			local_target_xfer_strobe_n_out <= 1'b1;
			local_target_write_data_out <= {LT_DATA_WIDTH{1'b0}};
			last_word <= 32'h00000000;
			set_ev <= {`PTA_ST_W{1'b0}};
		end else begin
			pclk_prev <= pclk;
			set_ev <= {`PTA_ST_W{1'b0}};
			local_target_xfer_strobe_n_out <= 1'b1;
			if (tick) begin
				frame_prev <= frame_n;
				case (state)
					ST_IDLE: begin
						rdy_d1_n <= 1'b1;
						if (frame_prev && !frame_n && target_en && (|bar_hit)) begin
							devsel_n <= 1'b0;
							drive <= 1'b1;
							state <= ST_CLAIM;
							set_ev[`PTA_ST_CLAIM] <= 1'b1;
						end
					end
					ST_CLAIM: begin
						rdy_d1_n <= local_target_ready_n_in;
						// a data phase ends when both ready lines are low
						if (!trdy_n && !irdy_n) begin
							local_target_xfer_strobe_n_out <= 1'b0;
							local_target_write_data_out <= ad[LT_DATA_WIDTH-1:0];
							last_word <= ad[31:0];
							set_ev[`PTA_ST_WORD] <= 1'b1;
						end
						if (!local_abort_request_n_in) begin
							// irdy is not looked at here
							devsel_n <= 1'b1;
							trdy_n <= 1'b1;
							stop_n <= 1'b0;
							state <= ST_ABORT;
						end else if (frame_n && !trdy_n && !irdy_n) begin
							devsel_n <= 1'b1;
							trdy_n <= 1'b1;
							state <= ST_DONE;
						end else begin
							// ready now, or ready one cycle earlier, holds trdy low
							trdy_n <= local_target_ready_n_in & rdy_d1_n;
						end
					end
					ST_ABORT: begin
						// frame goes first, then irdy ends the cycle
						if (frame_n && irdy_n) begin
							stop_n <= 1'b1;
							state <= ST_DONE;
							set_ev[`PTA_ST_ABORT] <= 1'b1;
						end
					end
					ST_DONE: begin
						// lines were driven high last cycle; now let go
						drive <= 1'b0;
						state <= ST_IDLE;
					end
					default: begin
						state <= ST_IDLE;
						devsel_n <= 1'b1;
						trdy_n <= 1'b1;
						stop_n <= 1'b1;
						drive <= 1'b0;
					end
				endcase
			end
		end
	end

	// software registers; a new event wins over a clear in the same cycle
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			target_en <= `PTA_CTRL_RST;
			latency <= `PTA_LAT_RST;
			status <= {`PTA_ST_W{1'b0}};
			mask <= {`PTA_ST_W{1'b0}};
			irq_out <= 1'b0;
		end else begin
			if (reg_write_in && reg_addr_in == `PTA_OFF_STATUS)
				status <= (status & ~reg_wdata_in[`PTA_ST_W-1:0]) | set_ev;
			else
				status <= status | set_ev;
			if (reg_write_in && reg_addr_in == `PTA_OFF_MASK)
				mask <= reg_wdata_in[`PTA_ST_W-1:0];
			if (reg_write_in && reg_addr_in == `PTA_OFF_CTRL)
				target_en <= reg_wdata_in[`PTA_CTRL_EN];
			// latency timer is fixed when built read-only
			if (reg_write_in && reg_addr_in == `PTA_OFF_LAT &&
				MT_VARIANT != 0 && LAT_READ_ONLY == 0)
				latency <= reg_wdata_in[7:0];
			irq_out <= |(status & mask);
		end
	end

	// read data stands in the cycle after the strobe only
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (!reg_read_in) begin
			reg_rdata_out <= 32'h00000000;
		end else begin
			case (reg_addr_in)
				`PTA_OFF_ID: reg_rdata_out <= {DEVICE_ID, VENDOR_ID};
				`PTA_OFF_CLASS: reg_rdata_out <= {BASE_CLASS, SUB_CLASS, PROG_IF,
					REVISION_ID};
				`PTA_OFF_SUBSYS: reg_rdata_out <= {SUBSYS_ID, SUBSYS_VENDOR_ID};
				`PTA_OFF_CIS: reg_rdata_out <= CIS_POINTER;
				`PTA_OFF_LAT: reg_rdata_out <= (MT_VARIANT != 0) ?
					{MAX_LATENCY, MIN_GRANT, 8'h00, latency} : 32'h00000000;
				`PTA_OFF_INFO: reg_rdata_out <= info_word;
				`PTA_OFF_CTRL: reg_rdata_out <= {31'h00000000, target_en};
				`PTA_OFF_STATUS: reg_rdata_out <= {29'h00000000, status};
				`PTA_OFF_MASK: reg_rdata_out <= {29'h00000000, mask};
				`PTA_OFF_DATA: reg_rdata_out <= last_word;
				`PTA_OFF_STATE: reg_rdata_out <= {25'h0000000, stop_n, trdy_n,
					devsel_n, state};
				8'h40: reg_rdata_out <= bar_value[31:0];
				8'h44: reg_rdata_out <= bar_value[63:32];
				8'h48: reg_rdata_out <= bar_value[95:64];
				8'h4c: reg_rdata_out <= bar_value[127:96];
				8'h50: reg_rdata_out <= bar_value[159:128];
				8'h54: reg_rdata_out <= bar_value[191:160];
				default: reg_rdata_out <= 32'h00000000;
			endcase
		end
	end
endmodule // pta_target

/* verif/pta_pci_master.sv */
// Purpose: pci bus master that runs one write frame at a time
// Assumes: target pins pulled up; clock stands still between frames
// Notes: drives and samples at the rising pci edge, like a real master
module pta_pci_master (
	input wire devsel_n_in,
	input wire trdy_n_in,
	input wire stop_n_in,
	output logic pci_clk_out,
	output logic frame_n_out,
	output logic irdy_n_out,
	output logic [3:0] cbe_n_out,
	output logic [31:0] ad_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic saw_claim = 1'b0;
	logic saw_abort = 1'b0;
	// idle bus, clock parked low
	initial begin
		pci_clk_out = 1'b0;
		frame_n_out = 1'b1;
		irdy_n_out = 1'b1;
		cbe_n_out = 4'hf;
		ad_out = 32'h0;
	end
	// half of the 800 ns pci period
	task half(input logic lvl);
		#400 pci_clk_out = lvl;
	endtask
	// burst keeps frame low so the frame ends on a target stop or after 12 cycles
	task xact(input logic [3:0] cmd, input logic [31:0] addr, data, input logic burst, late);
		int i;
		saw_claim = 1'b0;
		saw_abort = 1'b0;
		half(1'b1);
		half(1'b0);
		half(1'b1);
		frame_n_out = 1'b0;
		ad_out = addr;
		cbe_n_out = ~cmd;
		half(1'b0);
		half(1'b1);
		ad_out = data;
		cbe_n_out = 4'h0;
		irdy_n_out = late;
		frame_n_out = ~burst;
		for (i = 0; i < 12; i++) begin
			half(1'b0);
			half(1'b1);
			if (devsel_n_in === 1'b0) saw_claim = 1'b1;
			// abort seen: frame goes first, irdy one cycle later
			if (stop_n_in === 1'b0) begin
				saw_abort = 1'b1;
				frame_n_out = 1'b1;
				half(1'b0);
				half(1'b1);
				break;
			end
			if (trdy_n_in === 1'b0 && irdy_n_out === 1'b0 && !burst) break;
		end
		irdy_n_out = 1'b1;
		frame_n_out = 1'b1;
		ad_out = ~ad_out;
		cbe_n_out = ~cbe_n_out;
		repeat (3) begin
			half(1'b0);
			half(1'b1);
		end
		half(1'b0);
	endtask
endmodule // pta_pci_master

/* verif/pta_target_monitor.sv */
// Purpose: pin and register port checks of the pci target block
// Assumes: bound to every pta_target instance
// Notes: pci pins are judged on clock_in, where the block drives them
module pta_target_monitor (
	input wire clock_in,
	input wire reset_in,
	input wire devsel_n_out,
	input wire devsel_n_oe_n_out,
	input wire trdy_n_out,
	input wire trdy_n_oe_n_out,
	input wire stop_n_out,
	input wire stop_n_oe_n_out,
	input wire local_target_xfer_strobe_n_out,
	input wire reg_read_in,
	input wire [31:0] reg_rdata_out,
	input wire irq_out,
	input wire interrupt_line_a_n_oe_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);
	// one drive flop serves all three pins
	oe_same_a: assert property (devsel_n_oe_n_out == trdy_n_oe_n_out && trdy_n_oe_n_out ==
		stop_n_oe_n_out) else $error("pin enables differ");
	idle_high_a: assert property (devsel_n_oe_n_out |->
		devsel_n_out && trdy_n_out && stop_n_out) else $error("released pin not left high");
	claim_drive_a: assert property ($fell(devsel_n_out) |-> !devsel_n_oe_n_out)
		else $error("claim without driving devsel");
	trdy_claim_a: assert property (!trdy_n_out |-> !devsel_n_out && !trdy_n_oe_n_out)
		else $error("trdy low outside a claim");
	abort_pins_a: assert property ($fell(stop_n_out) |-> devsel_n_out && trdy_n_out)
		else $error("stop without devsel and trdy high");
	// after stop lets go the pins are driven high, then released
	stop_end_a: assert property ($rose(stop_n_out) |-> devsel_n_out && trdy_n_out
		##[1:12] devsel_n_oe_n_out) else $error("pins not released after abort");
	strobe_one_a: assert property ($fell(local_target_xfer_strobe_n_out) |=>
		local_target_xfer_strobe_n_out) else $error("strobe longer than one clock");
	strobe_cause_a: assert property ($fell(local_target_xfer_strobe_n_out) |->
		$past(trdy_n_out) == 1'b0 && $past(devsel_n_out) == 1'b0) else $error("word without trdy");
	rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
	intr_pin_a: assert property (interrupt_line_a_n_oe_n_out == !irq_out)
		else $error("interrupt pin differs from irq");
endmodule // pta_target_monitor

bind pta_target pta_target_monitor mon (.clock_in, .reset_in, .devsel_n_out, .devsel_n_oe_n_out,
	.trdy_n_out, .trdy_n_oe_n_out, .stop_n_out, .stop_n_oe_n_out, .local_target_xfer_strobe_n_out,
	.reg_read_in, .reg_rdata_out, .irq_out, .interrupt_line_a_n_oe_n_out);

/* verif/pta_target_test.sv */
// Purpose: self-checking bench of the pci target block
// Assumes: 10 MHz clock_in, pci clock made by the master model
// Notes: each test is a task; words handed over are caught below
`include "pta_defines.vh"
module pta_target_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic local_target_ready_n_in = 1'b1;
	logic local_abort_request_n_in = 1'b1;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic [31:0] reg_rdata_out, local_target_write_data_out, ad_in, last_word;
	logic [3:0] cbe_n_in;
	logic pci_clk_in, frame_n_in, irdy_n_in, devsel_n_out, devsel_n_oe_n_out, trdy_n_out;
	logic trdy_n_oe_n_out, stop_n_out, stop_n_oe_n_out, irq_out, local_target_xfer_strobe_n_out;
	logic interrupt_line_a_n_out, interrupt_line_a_n_oe_n_out;
	int err_count = 0;
	int checks = 0;
	int words = 0;
	// pulled-up pins read high once released
	wire devsel_pin = devsel_n_oe_n_out | devsel_n_out;
	wire trdy_pin = trdy_n_oe_n_out | trdy_n_out;
	wire stop_pin = stop_n_oe_n_out | stop_n_out;
	pta_target DUT (.clock_in, .reset_in, .pci_clk_in, .frame_n_in, .irdy_n_in, .cbe_n_in, .ad_in,
		.devsel_n_out, .devsel_n_oe_n_out, .trdy_n_out, .trdy_n_oe_n_out, .stop_n_out,
		.stop_n_oe_n_out, .interrupt_line_a_n_out, .interrupt_line_a_n_oe_n_out,
		.local_target_ready_n_in, .local_abort_request_n_in, .local_target_xfer_strobe_n_out,
		.local_target_write_data_out, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
		.reg_rdata_out, .irq_out);
	pta_pci_master bus (.devsel_n_in(devsel_pin), .trdy_n_in(trdy_pin), .stop_n_in(stop_pin),
		.pci_clk_out(pci_clk_in), .frame_n_out(frame_n_in), .irdy_n_out(irdy_n_in),
		.cbe_n_out(cbe_n_in), .ad_out(ad_in));
	initial forever #50 clock_in = ~clock_in;
	// each strobe hands over one word
	always @(posedge clock_in) begin
		if (local_target_xfer_strobe_n_out === 1'b0) begin
			words <= words + 1;
			last_word <= local_target_write_data_out;
		end
	end
	task chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task flag(input logic got, exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask
	// back-end: ready once claimed, abort after a word or after a pause
	task backend(input logic abort, after_word);
		int n;
		n = 0;
		@(posedge clock_in);
		while (devsel_n_out !== 1'b0 && n++ < 400) @(posedge clock_in);
		local_target_ready_n_in <= 1'b0;
		if (abort) begin
			n = 0;
			while (after_word && local_target_xfer_strobe_n_out !== 1'b0 && n++ < 400)
				@(posedge clock_in);
			repeat (after_word ? 1 : 16) @(posedge clock_in);
			local_abort_request_n_in <= 1'b0;
			n = 0;
			while (stop_n_out !== 1'b0 && n++ < 400) @(posedge clock_in);
			local_abort_request_n_in <= 1'b1;
		end
		n = 0;
		while (devsel_n_out !== 1'b1 && n++ < 400) @(posedge clock_in);
		local_target_ready_n_in <= 1'b1;
	endtask
	task test_header;
		rd(`PTA_OFF_ID, {16'h0000, `PTA_VENDOR_DEF});
		rd(`PTA_OFF_CLASS, 32'h05000001);
		rd(`PTA_OFF_SUBSYS, 32'h0);
		rd(`PTA_OFF_CIS, 32'h0);
		rd(`PTA_OFF_INFO, 32'h8);
		rd(8'h30, 32'h0);
		wr(`PTA_OFF_LAT, 32'h40);
		rd(`PTA_OFF_LAT, 32'h40);
		wr(8'h40, 32'hffffffff);
		rd(8'h40, 32'hfffffffd);
		wr(8'h44, 32'hffffffff);
		rd(8'h44, 32'hfffffff0);
		wr(8'h4c, 32'hffffffff);
		rd(8'h4c, 32'h0);
		wr(8'h40, 32'h100);
		wr(8'h44, 32'h10000000);
		$display("test_header done");
	endtask
	task test_abort;
		wr(`PTA_OFF_MASK, 32'h7);
		fork
			bus.xact(4'h7, 32'h10000004, 32'ha5c30f96, 1'b1, 1'b0);
			backend(1'b1, 1'b1);
		join
		flag(bus.saw_claim, 1'b1);
		flag(bus.saw_abort, 1'b1);
		chk(last_word, 32'ha5c30f96);
		rd(`PTA_OFF_STATUS, 32'h7);
		flag(irq_out, 1'b1);
		// pulled-up interrupt pin reads low while the block drives it
		flag(interrupt_line_a_n_oe_n_out | interrupt_line_a_n_out, 1'b0);
		rd(`PTA_OFF_MASK, 32'h7);
		wr(`PTA_OFF_STATUS, 32'h7);
		rd(`PTA_OFF_STATUS, 32'h0);
		flag(irq_out, 1'b0);
		flag(interrupt_line_a_n_oe_n_out | interrupt_line_a_n_out, 1'b1);
		$display("test_abort done");
	endtask
	// abort while the master holds irdy high: no word, abort all the same
	task test_irdy_high;
		int w0;
		w0 = words;
		wr(`PTA_OFF_MASK, 32'h0);
		fork
			bus.xact(4'h7, 32'h10000008, 32'h3c3c5a5a, 1'b1, 1'b1);
			backend(1'b1, 1'b0);
		join
		flag(bus.saw_abort, 1'b1);
		chk(words, w0);
		rd(`PTA_OFF_STATUS, 32'h5);
		flag(irq_out, 1'b0);
		wr(`PTA_OFF_STATUS, 32'h7);
		$display("test_irdy_high done");
	endtask
	// a new frame after the aborts, then a read that must be ignored
	task test_io;
		fork
			bus.xact(4'h3, 32'h100, 32'h12345678, 1'b0, 1'b0);
			backend(1'b0, 1'b0);
		join
		flag(bus.saw_claim, 1'b1);
		flag(bus.saw_abort, 1'b0);
		chk(last_word, 32'h12345678);
		rd(`PTA_OFF_STATUS, 32'h3);
		rd(`PTA_OFF_DATA, 32'h12345678);
		rd(`PTA_OFF_STATE, 32'h71);
		wr(`PTA_OFF_STATUS, 32'h7);
		bus.xact(4'h2, 32'h100, 32'h0, 1'b0, 1'b0);
		flag(bus.saw_claim, 1'b0);
		// a disabled target ignores even a matching write
		wr(`PTA_OFF_CTRL, 32'h0);
		bus.xact(4'h3, 32'h100, 32'h0, 1'b0, 1'b0);
		flag(bus.saw_claim, 1'b0);
		rd(`PTA_OFF_CTRL, 32'h0);
		wr(`PTA_OFF_CTRL, 32'h1);
		rd(`PTA_OFF_CTRL, 32'h1);
		rd(`PTA_OFF_STATUS, 32'h0);
		$display("test_io done");
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock_in);
		reset_in <= 1'b0;
		repeat (20) @(posedge clock_in);
		test_header;
		test_abort;
		test_irdy_high;
		test_io;
		report_and_stop;
	end
	// tests take well under 200 us
	initial begin
		#2000000;
		err_count++;
		$display("Error %0t: timeout", $time);
		report_and_stop;
	end
endmodule // pta_target_test
